// File: hw/sync_prot_pkg.sv
package sync_prot_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BLOCK_MON    = 8'h13;
  localparam logic [7:0] IDX_BLOCK_FORCE  = 8'h14;
  localparam logic [7:0] IDX_ACQ_STEPS    = 8'h18;
  localparam logic [7:0] IDX_HOLD_STEPS   = 8'h19;
  localparam logic [7:0] IDX_FRAME_MON    = 8'h1a;
  localparam logic [7:0] IDX_FRAME_SET    = 8'h1b;
  localparam logic [7:0] IDX_FRAME_CLR    = 8'h1c;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h1d;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h1e;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAIN_FORCE_LSB = 0;
  localparam int AUX_FORCE_LSB  = 4;
  localparam int MAIN_MON_BIT   = 0;
  localparam int AUX_MON_BIT    = 4;
  // Interrupt status bits
  localparam int IRQ_LOCK_BIT   = 0;
  localparam int IRQ_LOSS_BIT   = 1;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FORCE_CLEAR    = 2'h2;
  localparam logic [1:0] FORCE_SET      = 2'h1;
  localparam logic [1:0] ACQ_RESET      = 2'h1;
  localparam logic [3:0] HOLD_RESET     = 4'h4;
  localparam logic [1:0] IRQ_RESET      = 2'h0;
  localparam int         ADDR_W         = 10;
endpackage

// File: hw/sync_protection_control.sv
`timescale 1ns/1ps
// Functional notes
// - Writing 10 to bits 1:0 of the block force register drops main lock, 01 forces it.
// - Writing 10 to bits 5:4 of the block force register drops aux lock, 01 forces it.
// - The acquire setting is two bits, step count is code plus one, reset code 01.
// - Unlocked, frame lock is declared after step-count consecutive sync detections.
// - The hold setting is four bits from 1 to 15, resets to 4, and must never be zero; the code stores a written zero as is.
// - Locked, each detection reloads the remaining count and each miss decrements it.
// - Lock is lost when the remaining count goes 1 to 0; reads return the remaining count.
// - Frame monitor bit 0 shows frame lock, read only, reset 0.
// - Any write to the frame set strobe forces frame lock.
// - Any write to the frame clear strobe forces frame unlock.
// - Block monitor bit 0 shows main lock and bit 4 shows aux lock.
module sync_protection_control
  import sync_prot_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // Avalon-MM slave
  input  wire logic [sync_prot_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  // Sync point inputs from the demodulator (same clock)
  input  wire logic                        sync_slot_i,
  input  wire logic                        sync_hit_i,
  // Lock flags and interrupt
  output logic                             frame_lock_flag_o,
  output logic                             main_block_lock_flag_o,
  output logic                             aux_block_lock_flag_o,
  output logic                             irq_o
);
  import sync_prot_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  bus_state_t  bus_r, bus_nxt;
  logic [7:0]  idx;
  logic        wr_go, rd_go, rd_take, wr_lane0;
  logic [7:0]  wdat;
  logic [31:0] rdata_r, rdata_nxt;

  // Word index from the byte address
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  assign idx      = word_index(avs_address_i);
  assign wdat     = avs_writedata_i[7:0];
  assign wr_lane0 = avs_byteenable_i[0];
  // One wait cycle, then acknowledge
  assign wr_go    = (bus_r == BUS_ACK) && avs_write_i;
  assign rd_go    = (bus_r == BUS_ACK) && avs_read_i;
  assign rd_take  = (bus_r == BUS_IDLE) && avs_read_i; // Read first seen, load read data
  assign avs_waitrequest_o = !(bus_r == BUS_ACK);
  assign avs_readdata_o    = rdata_r;

  // Bus handshake sequencing
  always_comb begin
    bus_nxt = BUS_IDLE;
    unique case (bus_r)
      BUS_IDLE: bus_nxt = (avs_read_i || avs_write_i) ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_nxt = BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register and lock state
  // ----------------------------------------------------------------
  logic       main_lock_r, main_lock_nxt;
  logic       aux_lock_r, aux_lock_nxt;
  logic [1:0] acq_r, acq_nxt;
  logic [3:0] hold_r, hold_nxt;
  logic [3:0] remain_r, remain_nxt;
  logic [1:0] hits_r, hits_nxt;
  logic       frame_r, frame_nxt;
  logic [1:0] irq_st_r, irq_st_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic       ev_lock, ev_loss;

  // Block force and settings writes
  always_comb begin
    main_lock_nxt = main_lock_r;
    aux_lock_nxt  = aux_lock_r;
    acq_nxt       = acq_r;
    hold_nxt      = hold_r;
    irq_mask_nxt  = irq_mask_r;
    if (wr_go && wr_lane0) begin
      unique case (idx)
        IDX_BLOCK_FORCE: begin
          // Only 01 and 10 act; 00 and 11 hold state
          if (wdat[MAIN_FORCE_LSB +: 2] == FORCE_CLEAR) main_lock_nxt = 1'b0;
          if (wdat[MAIN_FORCE_LSB +: 2] == FORCE_SET)   main_lock_nxt = 1'b1;
          if (wdat[AUX_FORCE_LSB +: 2] == FORCE_CLEAR)  aux_lock_nxt  = 1'b0;
          if (wdat[AUX_FORCE_LSB +: 2] == FORCE_SET)    aux_lock_nxt  = 1'b1;
        end
        IDX_ACQ_STEPS:  acq_nxt      = wdat[1:0];
        IDX_HOLD_STEPS: hold_nxt     = wdat[3:0];
        IDX_IRQ_MASK:   irq_mask_nxt = wdat[1:0];
        default: ;
      endcase
    end
  end

  // Frame synchronizer
  always_comb begin
    frame_nxt  = frame_r;
    remain_nxt = remain_r;
    hits_nxt   = hits_r;
    ev_lock    = 1'b0;
    ev_loss    = 1'b0;
    if (!frame_r) begin
      if (sync_slot_i) begin
        if (!sync_hit_i) begin
          hits_nxt = 2'h0;
        end else if (hits_r == acq_r) begin
          // Consecutive hits reached code plus one
          frame_nxt  = 1'b1;
          remain_nxt = hold_r;
          hits_nxt   = 2'h0;
          ev_lock    = 1'b1;
        end else begin
          hits_nxt = hits_r + 2'h1;
        end
      end
    end else if (sync_slot_i) begin
      if (sync_hit_i) begin
        remain_nxt = hold_r;
      end else if (remain_r == 4'h1) begin
        remain_nxt = 4'h0;
        frame_nxt  = 1'b0;
        ev_loss    = 1'b1;
      end else if (remain_r != 4'h0) begin
        remain_nxt = remain_r - 4'h1;
      end
    end
    // Host strobes override detection
    if (wr_go && idx == IDX_FRAME_SET) begin
      frame_nxt  = 1'b1;
      remain_nxt = hold_r;
      hits_nxt   = 2'h0;
      ev_lock    = !frame_r;
    end else if (wr_go && idx == IDX_FRAME_CLR) begin
      frame_nxt  = 1'b0;
      hits_nxt   = 2'h0;
      ev_loss    = frame_r;
    end
  end

  // Interrupt status, set wins over read clear
  always_comb begin
    irq_st_nxt = irq_st_r;
    if (rd_go && idx == IDX_IRQ_STATUS) irq_st_nxt = IRQ_RESET;
    if (ev_lock) irq_st_nxt[IRQ_LOCK_BIT] = 1'b1;
    if (ev_loss) irq_st_nxt[IRQ_LOSS_BIT] = 1'b1;
  end

  // Read data mux, loaded at the edge that first sees the read
  // so the word stands while waitrequest is low
  always_comb begin
    rdata_nxt = 32'h0;
    if (rd_take) begin
      unique case (idx)
        IDX_BLOCK_MON: begin
          rdata_nxt[MAIN_MON_BIT] = main_lock_r;
          rdata_nxt[AUX_MON_BIT]  = aux_lock_r;
        end
        IDX_HOLD_STEPS: rdata_nxt[3:0] = remain_r;
        IDX_FRAME_MON:  rdata_nxt[0]   = frame_r;
        IDX_IRQ_STATUS: rdata_nxt[1:0] = irq_st_nxt; // Events at the load edge are not lost
        IDX_IRQ_MASK:   rdata_nxt[1:0] = irq_mask_r;
        default: ;
      endcase
    end
  end

  // Bus handshake register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // Read data register, zero outside the acknowledge cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Block lock and settings registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_lock_r <= 1'b0;
      aux_lock_r  <= 1'b0;
      acq_r       <= ACQ_RESET;
      hold_r      <= HOLD_RESET;
      irq_mask_r  <= IRQ_RESET;
    end else begin
      main_lock_r <= main_lock_nxt;
      aux_lock_r  <= aux_lock_nxt;
      acq_r       <= acq_nxt;
      hold_r      <= hold_nxt;
      irq_mask_r  <= irq_mask_nxt;
    end
  end

  // Frame synchronizer registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remain_r <= HOLD_RESET;
      hits_r   <= 2'h0;
      frame_r  <= 1'b0;
    end else begin
      remain_r <= remain_nxt;
      hits_r   <= hits_nxt;
      frame_r  <= frame_nxt;
    end
  end

  // Interrupt status register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_st_r <= IRQ_RESET;
    end else begin
      irq_st_r <= irq_st_nxt;
    end
  end

  // Outputs
  assign frame_lock_flag_o      = frame_r;
  assign main_block_lock_flag_o = main_lock_r;
  assign aux_block_lock_flag_o  = aux_lock_r;
  assign irq_o                  = |(irq_st_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_force_main(logic [1:0] c);
    wr_go && wr_lane0 && idx == IDX_BLOCK_FORCE && wdat[1:0] == c;
  endsequence

  sequence s_force_aux(logic [1:0] c);
    wr_go && wr_lane0 && idx == IDX_BLOCK_FORCE && wdat[5:4] == c;
  endsequence

  a_main_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_force_main(FORCE_CLEAR) |=> !main_block_lock_flag_o)
    else $error("main lock not cleared");
  a_aux_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_go && wr_lane0 && idx == IDX_BLOCK_FORCE && wdat[5:4] == FORCE_SET
    |=> aux_block_lock_flag_o)
    else $error("aux lock not set");
  a_force_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_force_main(2'h0) or s_force_main(2'h3)) |=> $stable(main_block_lock_flag_o))
    else $error("main lock moved on no-op code");
  a_acq_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(frame_r) && !$past(wr_go) |-> $past(hits_r) == $past(acq_r))
    else $error("lock before acquire count");
  a_hold_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
    frame_r && sync_slot_i && sync_hit_i && !wr_go |=> remain_r == $past(hold_r))
    else $error("remaining count not reloaded");
  a_loss_edge: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(frame_r) && !$past(wr_go) |-> $past(remain_r) == 4'h1 && remain_r == 4'h0)
    else $error("lock lost off 1 to 0");
  a_set_strobe: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_go && idx == IDX_FRAME_SET |=> frame_lock_flag_o)
    else $error("frame set strobe ignored");
  a_clr_strobe: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_go && idx == IDX_FRAME_CLR |=> !frame_lock_flag_o)
    else $error("frame clear strobe ignored");
  a_frame_mon: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_go && idx == IDX_FRAME_MON |-> avs_readdata_o == {31'h0, $past(frame_r)})
    else $error("frame monitor wrong");
  a_main_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_force_main(FORCE_SET) |=> main_block_lock_flag_o)
    else $error("main lock not set");
  a_aux_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_force_aux(FORCE_CLEAR) |=> !aux_block_lock_flag_o)
    else $error("aux lock not cleared");
  a_aux_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_force_aux(2'h0) or s_force_aux(2'h3)) |=> $stable(aux_block_lock_flag_o))
    else $error("aux lock moved on no-op code");
  a_acq_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_go && wr_lane0 && idx == IDX_ACQ_STEPS |=> acq_r == $past(wdat[1:0]))
    else $error("acquire setting not stored");
  a_hold_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_go && wr_lane0 && idx == IDX_HOLD_STEPS |=> hold_r == $past(wdat[3:0]))
    else $error("hold setting not stored");
  a_hold_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    frame_r && sync_slot_i && !sync_hit_i && remain_r > 4'h1 && !wr_go
    |=> remain_r == $past(remain_r) - 4'h1)
    else $error("remaining count not decremented");
  a_hold_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_go && idx == IDX_HOLD_STEPS |-> avs_readdata_o[3:0] == $past(remain_r))
    else $error("hold read not remaining count");
  a_block_mon: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_go && idx == IDX_BLOCK_MON |-> avs_readdata_o[AUX_MON_BIT] == $past(aux_lock_r)
    && avs_readdata_o[MAIN_MON_BIT] == $past(main_lock_r))
    else $error("block monitor wrong");
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  import sync_prot_pkg::*;
  logic              clk_i, nrst_i, avs_read_i, avs_write_i, sync_slot_i, sync_hit_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic [31:0]       avs_writedata_i, avs_readdata_o;
  logic [3:0]        avs_byteenable_i;
  logic              avs_waitrequest_o, frame_lock_flag_o, irq_o;
  logic              main_block_lock_flag_o, aux_block_lock_flag_o;
  logic [7:0]        rd;
  int                errors, total_checks;
  sync_protection_control DUT (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sync_slot_i(sync_slot_i), .sync_hit_i(sync_hit_i),
    .frame_lock_flag_o(frame_lock_flag_o), .main_block_lock_flag_o(main_block_lock_flag_o),
    .aux_block_lock_flag_o(aux_block_lock_flag_o), .irq_o(irq_o));
  // ----------------------------------------------------------------
  // Verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One Avalon transfer; waitrequest and read data taken at one rising edge
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_write_i     <= we;
    avs_read_i      <= !we;
    avs_writedata_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      close_out();
    end
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // Let the flags settle before the caller looks
    @(negedge clk_i);
  endtask
  // One sync point, then let the lock logic settle
  task automatic slot(input logic hit);
    @(posedge clk_i);
    sync_slot_i <= 1'b1;
    sync_hit_i  <= hit;
    @(posedge clk_i);
    sync_slot_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    bus(0, IDX_HOLD_STEPS, 8'h0); `CHK(rd, 8'h04)
    bus(0, IDX_FRAME_MON, 8'h0); `CHK(rd, 8'h00)
    bus(0, IDX_BLOCK_MON, 8'h0); `CHK(rd, 8'h00)
    bus(0, 8'h05, 8'h0); `CHK(rd, 8'h00)
  endtask
  task automatic t_block();
    bus(1, IDX_BLOCK_FORCE, 8'h01); `CHK(main_block_lock_flag_o, 1'b1)
    `CHK(aux_block_lock_flag_o, 1'b0)
    bus(1, IDX_BLOCK_FORCE, 8'h13); `CHK(aux_block_lock_flag_o, 1'b1)
    bus(0, IDX_BLOCK_MON, 8'h0); `CHK(rd, 8'h11)
    bus(1, IDX_BLOCK_FORCE, 8'h30); `CHK(main_block_lock_flag_o, 1'b1)
    bus(1, IDX_BLOCK_FORCE, 8'h02); `CHK(main_block_lock_flag_o, 1'b0)
    `CHK(aux_block_lock_flag_o, 1'b1)
    bus(1, IDX_BLOCK_FORCE, 8'h20); `CHK(aux_block_lock_flag_o, 1'b0)
    bus(0, IDX_BLOCK_MON, 8'h0); `CHK(rd, 8'h00)
  endtask
  task automatic t_acquire();
    slot(1); `CHK(frame_lock_flag_o, 1'b0)
    slot(0); slot(1); `CHK(frame_lock_flag_o, 1'b0)
    slot(1); `CHK(frame_lock_flag_o, 1'b1)
    bus(0, IDX_FRAME_MON, 8'h0); `CHK(rd, 8'h01)
  endtask
  task automatic t_hold();
    bus(1, IDX_HOLD_STEPS, 8'h02);
    slot(1); bus(0, IDX_HOLD_STEPS, 8'h0); `CHK(rd, 8'h02)
    slot(0); bus(0, IDX_HOLD_STEPS, 8'h0); `CHK(rd, 8'h01)
    `CHK(frame_lock_flag_o, 1'b1)
    slot(1); bus(0, IDX_HOLD_STEPS, 8'h0); `CHK(rd, 8'h02)
    slot(0); slot(0); `CHK(frame_lock_flag_o, 1'b0)
    bus(0, IDX_HOLD_STEPS, 8'h0); `CHK(rd, 8'h00)
  endtask
  task automatic t_strobe();
    bus(1, IDX_FRAME_SET, 8'h00); `CHK(frame_lock_flag_o, 1'b1)
    bus(1, IDX_FRAME_CLR, 8'hff); `CHK(frame_lock_flag_o, 1'b0)
    bus(1, IDX_FRAME_SET, 8'ha5); bus(0, IDX_FRAME_MON, 8'h0); `CHK(rd, 8'h01)
    bus(1, IDX_FRAME_CLR, 8'h00); bus(0, IDX_FRAME_MON, 8'h0); `CHK(rd, 8'h00)
  endtask
  // Four hits needed with code 3; gain event raises the masked interrupt
  task automatic t_irq();
    bus(1, IDX_ACQ_STEPS, 8'h03);
    bus(0, IDX_IRQ_STATUS, 8'h0);
    bus(1, IDX_IRQ_MASK, 8'h01);
    slot(1); slot(1); slot(1); `CHK(frame_lock_flag_o, 1'b0)
    `CHK(irq_o, 1'b0)
    slot(1); `CHK(frame_lock_flag_o, 1'b1)
    `CHK(irq_o, 1'b1)
    bus(0, IDX_IRQ_STATUS, 8'h0); `CHK(rd[0], 1'b1)
    `CHK(irq_o, 1'b0)
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    errors = 0; total_checks = 0; nrst_i = 1'b0;
    avs_read_i = 1'b0; avs_write_i = 1'b0; avs_address_i = '0;
    avs_writedata_i = '0; avs_byteenable_i = 4'hf; sync_slot_i = 1'b0; sync_hit_i = 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset(); t_block(); t_acquire(); t_hold(); t_strobe(); t_irq();
    close_out();
  end
endmodule
